// >>> rtl/clock_select_defs.vh
/*
  Register offsets, field positions, reset values and timing counts for
  the clock select and distribution block.
  Assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef CLOCK_SELECT_DEFS_VH
`define CLOCK_SELECT_DEFS_VH

// Register byte offsets
`define OFS_MAIN_CTRL 8'h00
`define OFS_FLL_CTRL 8'h04
`define OFS_PERIPH_SEL 8'h08
`define OFS_STATUS 8'h0C

// Main control fields
`define MAIN_SRC_LSB 0
`define MAIN_DIV_LSB 4
`define SUB_DIV_LSB 8
`define AUX_SRC_LSB 12

// Main source codes
`define MAIN_SRC_DCO 2'h0
`define MAIN_SRC_CRYSTAL 2'h1
`define MAIN_SRC_RC32K 2'h2
`define MAIN_SRC_VLO 2'h3

// Auxiliary source codes
`define AUX_SRC_CRYSTAL 2'h0
`define AUX_SRC_VLO 2'h1
`define AUX_SRC_RC32K 2'h2

// Frequency-lock control fields
`define FLL_MULT_LSB 0
`define FLL_MULT_W 10
`define FLL_EN_BIT 16
`define FLL_REF_BIT 17

// Peripheral select fields, two bits per peripheral from bit 0
`define PERIPH_SEL_W 2
`define RTC_CHOICE_BIT 24

// Status fields
`define STAT_FAULT_BIT 0
`define STAT_LOCK_BIT 1
`define STAT_TRIM_LSB 16
`define TRIM_W 9

// Reset values
`define MAIN_CTRL_RESET 32'h00000000
`define FLL_CTRL_RESET 32'h00000100
`define PERIPH_SEL_RESET 32'h00000000
`define TRIM_RESET 9'h100

// Source bus positions
`define SRC_OFF 4'h0
`define SRC_MAIN 4'h1
`define SRC_SUB 4'h2
`define SRC_AUX 4'h3
`define SRC_CRYSTAL 4'h4
`define SRC_VLO 4'h5
`define SRC_ASYNC_MODULE_OSC 4'h6
`define SRC_RC32K 4'h7
`define SRC_DCO 4'h8
`define SRC_PIN 4'h9

// Timing
`define CLOCK_PERIOD_NS 50
`define XT_FAULT_TIME_NS 100000
`define XT_FAULT_CYCLES (`XT_FAULT_TIME_NS / `CLOCK_PERIOD_NS)

`endif

// >>> rtl/clock_switch.v
/*
  Glitch-free clock selector over a 16-wide bus of sampled clock levels.
  Assumes all sources are already synchronised to clock.
*/
`timescale 1ns/1ns
`default_nettype none

module clock_switch (
  input wire clock,
  input wire nrst,
  input wire [15:0] sources,
  input wire [3:0] index,
  output reg out
);

  localparam FOLLOW = 1'b0;
  localparam PARK = 1'b1;

  reg state;
  reg [3:0] cur;

  // Leave old source only in its low phase, join new one in its low phase
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= FOLLOW;
      cur <= 4'h0;
      out <= 1'b0;
    end else begin
      case (state)
        FOLLOW: begin
          if (index != cur && !sources[cur]) begin
            state <= PARK;
            cur <= index;
            out <= 1'b0;
          end else begin
            out <= sources[cur];
          end
        end
        PARK: begin
          out <= 1'b0;
          if (!sources[cur]) begin
            state <= FOLLOW;
          end
        end
        default: begin
          state <= FOLLOW;
          out <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> rtl/pow2_divider.v
/*
  Divides a sampled clock level by 2 to the power exp (exp 0..7).
  Assumes src is synchronous to clock; output lags src by one cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module pow2_divider (
  input wire clock,
  input wire nrst,
  input wire src,
  input wire [2:0] exp,
  output reg out
);

  reg prev;
  reg [6:0] count;
  reg [2:0] cur;

  function [6:0] terminal;
    input [2:0] e;
    begin
      terminal = 7'h7F >> (3'h7 - e);
    end
  endfunction

  // Toggles after 2^exp source edges; new factor taken at a falling output or while output low with count zero
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev <= 1'b0;
      count <= 7'h00;
      cur <= 3'h0;
      out <= 1'b0;
    end else begin
      prev <= src;
      if (src != prev) begin
        if (count == terminal(cur)) begin
          count <= 7'h00;
          out <= ~out;
          if (out) begin
            cur <= exp;
          end
        end else begin
          count <= count + 7'h01;
        end
      end else if (!out && count == 7'h00) begin
        cur <= exp;
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/clock_select_and_distribution.v
/*
  Clock select and distribution: main, sub-system and auxiliary clocks,
  frequency-lock trim for the controlled oscillator, crystal fail-safe and
  the per-peripheral clock source selects, with an AHB-Lite register slave.
  Assumes oscillator and pin clocks are slow against clock and arrive
  asynchronously; they are synchronised here.
*/
// Function
// - The main clock picks the controlled, crystal, 32 kHz RC or very-low-power osc and divides it by 1 to 128.
// - The sub-system clock is the main clock divided by 1, 2, 4 or 8.
// - The auxiliary clock comes from the crystal, the very-low-power or the 32 kHz RC osc.
// - The controlled oscillator may be frequency-locked to the internal or external 32 kHz.
// - A failed crystal is replaced by another clock source automatically.
// - CPU, memories, checksum, multiplier and I/O run on the main clock with no select.
// - Timers 0 and 2 decode 00 pin, 01 aux, 10 sub-system, 11 very-low-power clock.
// - Timers 1, 3 and the seven-channel timer decode 00 pin, 01 aux, 10 sub-system only.
// - Serial units decode 00 pin, 01 aux, and 10 or 11 as sub-system clock.
// - The watchdog decodes 00 sub-system, 01 aux, 10 very-low-power clock.
// - The converter decodes 00 module oscillator, 01 aux, 10 or 11 sub-system clock.
// - The RTC decodes 10 crystal, 11 oscillator clock, and 01 per a fast/slow choice bit.
`include "clock_select_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module clock_select_and_distribution (
  input wire clock,
  input wire nrst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire crystal_osc_clock,
  input wire very_low_power_osc_clock,
  input wire internal_rc_32k_osc,
  input wire digitally_controlled_osc,
  input wire module_osc_clock,
  input wire timer0_ext_clock_pin,
  input wire timer1_ext_clock_pin,
  input wire timer2_ext_clock_pin,
  input wire timer3_ext_clock_pin,
  input wire timer_b_ext_clock_pin,
  input wire serial0_ext_clock_pin,
  input wire serial1_ext_clock_pin,
  input wire serial2_ext_clock_pin,
  input wire serial3_ext_clock_pin,
  output wire main_clock,
  output wire sub_system_clock,
  output wire aux_clock,
  output wire timer0_clock,
  output wire timer1_clock,
  output wire timer2_clock,
  output wire timer3_clock,
  output wire timer_b_clock,
  output wire serial0_clock,
  output wire serial1_clock,
  output wire serial2_clock,
  output wire serial3_clock,
  output wire watchdog_clock,
  output wire converter_clock,
  output wire rtc_clock,
  output reg [8:0] dco_trim,
  output reg crystal_fault
);

  // Peripheral slots on the select register
  localparam [3:0] P_TIMER0 = 4'h0;
  localparam [3:0] P_TIMER1 = 4'h1;
  localparam [3:0] P_TIMER2 = 4'h2;
  localparam [3:0] P_TIMER3 = 4'h3;
  localparam [3:0] P_TIMER_B = 4'h4;
  localparam [3:0] P_SERIAL0 = 4'h5;
  localparam [3:0] P_SERIAL3 = 4'h8;
  localparam [3:0] P_WATCHDOG = 4'h9;
  localparam [3:0] P_CONVERTER = 4'hA;
  localparam [3:0] P_RTC = 4'hB;

  // Two-flop synchronisers for oscillators and pins
  wire [13:0] async_in;
  reg [13:0] sync_a;
  reg [13:0] sync_b;

  assign async_in = {serial3_ext_clock_pin, serial2_ext_clock_pin, serial1_ext_clock_pin,
                     serial0_ext_clock_pin, timer_b_ext_clock_pin, timer3_ext_clock_pin,
                     timer2_ext_clock_pin, timer1_ext_clock_pin, timer0_ext_clock_pin,
                     module_osc_clock, digitally_controlled_osc, internal_rc_32k_osc,
                     very_low_power_osc_clock, crystal_osc_clock};

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 14'h0000;
      sync_b <= 14'h0000;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end

  wire xt_s = sync_b[0];
  wire vlo_s = sync_b[1];
  wire rc_s = sync_b[2];
  wire dco_s = sync_b[3];
  wire mod_s = sync_b[4];
  wire [8:0] pin_s = sync_b[13:5];

  // Registers
  reg [31:0] main_ctrl;
  reg [31:0] fll_ctrl;
  reg [31:0] periph_sel;
  reg fll_locked;

  // Crystal fail-safe: no edge for the timeout marks a fault
  reg xt_prev;
  reg [15:0] xt_idle;
  reg xt_eff;
  reg use_rc;
  reg rc_prev;
  wire fault_event = (xt_idle == `XT_FAULT_CYCLES - 1);
  reg fault_clear;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      xt_prev <= 1'b0;
      xt_idle <= 16'h0000;
      crystal_fault <= 1'b0;
    end else begin
      xt_prev <= xt_s;
      if (xt_s != xt_prev) begin
        xt_idle <= 16'h0000;
      end else if (xt_idle != `XT_FAULT_CYCLES) begin
        xt_idle <= xt_idle + 16'h0001;
      end
      if (fault_event) begin
        crystal_fault <= 1'b1;
      end else if (fault_clear) begin
        crystal_fault <= 1'b0;
      end
    end
  end

  // Faulted crystal replaced by the RC oscillator everywhere it is used.
  // Hand-over only at an RC falling edge, so no runt pulse reaches users;
  // a dead crystal may be left at any level, a live one rejoined only while low.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      use_rc <= 1'b0;
      rc_prev <= 1'b0;
      xt_eff <= 1'b0;
    end else begin
      rc_prev <= rc_s;
      if (use_rc != crystal_fault && rc_prev && !rc_s && (crystal_fault || !xt_s)) begin
        use_rc <= crystal_fault;
        xt_eff <= 1'b0;
      end else begin
        xt_eff <= use_rc ? rc_s : xt_s;
      end
    end
  end

  // Main clock: source switch then 1..128 divider
  reg [3:0] main_index;
  wire main_raw;
  wire main_div;

  always @* begin
    case (main_ctrl[`MAIN_SRC_LSB +: 2])
      `MAIN_SRC_CRYSTAL: main_index = `SRC_CRYSTAL;
      `MAIN_SRC_RC32K: main_index = `SRC_RC32K;
      `MAIN_SRC_VLO: main_index = `SRC_VLO;
      default: main_index = `SRC_DCO;
    endcase
  end

  // Auxiliary clock index
  reg [3:0] aux_index;
  always @* begin
    case (main_ctrl[`AUX_SRC_LSB +: 2])
      `AUX_SRC_VLO: aux_index = `SRC_VLO;
      `AUX_SRC_RC32K: aux_index = `SRC_RC32K;
      default: aux_index = `SRC_CRYSTAL;
    endcase
  end

  wire [15:0] common_src;
  wire aux_raw;
  assign common_src = {7'h00, dco_s, rc_s, mod_s, vlo_s, xt_eff, aux_raw, sub_system_clock,
                       main_clock, 1'b0};

  clock_switch u_main_switch (
    .clock(clock),
    .nrst(nrst),
    .sources(common_src),
    .index(main_index),
    .out(main_raw)
  );

  pow2_divider u_main_div (
    .clock(clock),
    .nrst(nrst),
    .src(main_raw),
    .exp(main_ctrl[`MAIN_DIV_LSB +: 3]),
    .out(main_div)
  );

  // CPU, memories, checksum, multiplier and I/O take this directly
  assign main_clock = main_div;

  pow2_divider u_sub_div (
    .clock(clock),
    .nrst(nrst),
    .src(main_div),
    .exp({1'b0, main_ctrl[`SUB_DIV_LSB +: 2]}),
    .out(sub_system_clock)
  );

  clock_switch u_aux_switch (
    .clock(clock),
    .nrst(nrst),
    .sources(common_src),
    .index(aux_index),
    .out(aux_raw)
  );
  assign aux_clock = aux_raw;

  // Peripheral source decode
  function [3:0] periph_index;
    input [3:0] slot;
    input [1:0] code;
    input fast_slow;
    begin
      periph_index = `SRC_OFF;
      if (slot == P_TIMER0 || slot == P_TIMER2) begin
        case (code)
          2'h0: periph_index = `SRC_PIN;
          2'h1: periph_index = `SRC_AUX;
          2'h2: periph_index = `SRC_SUB;
          default: periph_index = `SRC_VLO;
        endcase
      end else if (slot == P_TIMER1 || slot == P_TIMER3 || slot == P_TIMER_B) begin
        case (code)
          2'h0: periph_index = `SRC_PIN;
          2'h1: periph_index = `SRC_AUX;
          2'h2: periph_index = `SRC_SUB;
          default: periph_index = `SRC_OFF;
        endcase
      end else if (slot >= P_SERIAL0 && slot <= P_SERIAL3) begin
        case (code)
          2'h0: periph_index = `SRC_PIN;
          2'h1: periph_index = `SRC_AUX;
          default: periph_index = `SRC_SUB;
        endcase
      end else if (slot == P_WATCHDOG) begin
        case (code)
          2'h0: periph_index = `SRC_SUB;
          2'h1: periph_index = `SRC_AUX;
          2'h2: periph_index = `SRC_VLO;
          default: periph_index = `SRC_OFF;
        endcase
      end else if (slot == P_CONVERTER) begin
        case (code)
          2'h0: periph_index = `SRC_ASYNC_MODULE_OSC;
          2'h1: periph_index = `SRC_AUX;
          default: periph_index = `SRC_SUB;
        endcase
      end else if (slot == P_RTC) begin
        case (code)
          2'h1: periph_index = fast_slow ? `SRC_AUX : `SRC_SUB;
          2'h2: periph_index = `SRC_CRYSTAL;
          2'h3: periph_index = `SRC_VLO;
          default: periph_index = `SRC_OFF;
        endcase
      end
    end
  endfunction

  wire [11:0] periph_clk;
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : g_periph
      localparam integer SLOT = g;
      wire own_pin;
      wire [3:0] idx;
      if (g < 9) begin : g_pin
        assign own_pin = pin_s[g];
      end else begin : g_nopin
        assign own_pin = 1'b0;
      end
      assign idx = periph_index(SLOT[3:0], periph_sel[2*g +: 2], periph_sel[`RTC_CHOICE_BIT]);
      clock_switch u_switch (
        .clock(clock),
        .nrst(nrst),
        .sources({common_src[15:10], own_pin, common_src[8:0]}),
        .index(idx),
        .out(periph_clk[g])
      );
    end
  endgenerate

  assign timer0_clock = periph_clk[0];
  assign timer1_clock = periph_clk[1];
  assign timer2_clock = periph_clk[2];
  assign timer3_clock = periph_clk[3];
  assign timer_b_clock = periph_clk[4];
  assign serial0_clock = periph_clk[5];
  assign serial1_clock = periph_clk[6];
  assign serial2_clock = periph_clk[7];
  assign serial3_clock = periph_clk[8];
  assign watchdog_clock = periph_clk[9];
  assign converter_clock = periph_clk[10];
  assign rtc_clock = periph_clk[11];

  // Frequency lock: count oscillator edges per reference period, nudge trim
  wire ref_s = fll_ctrl[`FLL_REF_BIT] ? xt_eff : rc_s;
  reg ref_prev;
  reg dco_prev;
  reg [15:0] dco_count;
  wire [15:0] mult = {6'h00, fll_ctrl[`FLL_MULT_LSB +: `FLL_MULT_W]};

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ref_prev <= 1'b0;
      dco_prev <= 1'b0;
      dco_count <= 16'h0000;
      dco_trim <= `TRIM_RESET;
      fll_locked <= 1'b0;
    end else begin
      ref_prev <= ref_s;
      dco_prev <= dco_s;
      if (ref_s && !ref_prev) begin
        dco_count <= 16'h0000;
        fll_locked <= fll_ctrl[`FLL_EN_BIT] && (dco_count == mult);
        if (fll_ctrl[`FLL_EN_BIT]) begin
          if (dco_count < mult && dco_trim != 9'h1FF) begin
            dco_trim <= dco_trim + 9'h001;
          end else if (dco_count > mult && dco_trim != 9'h000) begin
            dco_trim <= dco_trim - 9'h001;
          end
        end
      end else if (dco_s && !dco_prev && dco_count != 16'hFFFF) begin
        dco_count <= dco_count + 16'h0001;
      end
    end
  end

  // AHB-Lite slave: writes zero wait, reads one wait state
  reg wr_pend;
  reg rd_pend;
  reg [7:0] addr_q;
  wire take = hsel && htrans[1] && hready;

  function [31:0] read_mux;
    input [7:0] a;
    input [31:0] mc;
    input [31:0] fc;
    input [31:0] ps;
    input [31:0] st;
    begin
      case (a)
        `OFS_MAIN_CTRL: read_mux = mc;
        `OFS_FLL_CTRL: read_mux = fc;
        `OFS_PERIPH_SEL: read_mux = ps;
        `OFS_STATUS: read_mux = st;
        default: read_mux = 32'h00000000;
      endcase
    end
  endfunction

  wire [31:0] status_word = {7'h00, dco_trim, 14'h0000, fll_locked, crystal_fault};

  always @* begin
    fault_clear = wr_pend && addr_q == `OFS_STATUS && hwdata[`STAT_FAULT_BIT];
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
      main_ctrl <= `MAIN_CTRL_RESET;
      fll_ctrl <= `FLL_CTRL_RESET;
      periph_sel <= `PERIPH_SEL_RESET;
    end else begin
      wr_pend <= 1'b0;
      if (wr_pend) begin
        case (addr_q)
          `OFS_MAIN_CTRL: main_ctrl <= hwdata & 32'h00003377;
          `OFS_FLL_CTRL: fll_ctrl <= hwdata & 32'h000303FF;
          `OFS_PERIPH_SEL: periph_sel <= hwdata & 32'h01FFFFFF;
          default: ;
        endcase
      end
      if (rd_pend) begin
        rd_pend <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= read_mux(addr_q, main_ctrl, fll_ctrl, periph_sel, status_word);
      end else if (take) begin
        addr_q <= {haddr[7:2], 2'b00};
        if (hwrite) begin
          wr_pend <= 1'b1;
        end else begin
          rd_pend <= 1'b1;
          hreadyout <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/_unused_placeholder_none.v
/*
  Empty unit kept to close the file list; holds no logic.
  Assumes nothing.
*/
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> dv/clock_select_and_distribution_assertions.sv
/*
  Port-level checker for the clock select block.
  Assumes every source clock phase lasts at least 3 system clock cycles.
*/
`include "clock_select_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module clock_select_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic main_clock,
  input wire logic sub_system_clock,
  input wire logic aux_clock,
  input wire logic timer0_clock,
  input wire logic serial0_clock,
  input wire logic [8:0] dco_trim,
  input wire logic crystal_fault
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire take = hsel && htrans[1] && hready;

  AST_MAIN_HIGH: assert property ($rose(main_clock) |-> main_clock [*3])
    else $error("main clock high phase too short");
  AST_MAIN_LOW: assert property ($fell(main_clock) |-> !main_clock [*3])
    else $error("main clock low phase too short");
  AST_SUB_HIGH: assert property ($rose(sub_system_clock) |-> sub_system_clock [*3])
    else $error("sub-system clock high phase too short");
  AST_AUX_HIGH: assert property ($rose(aux_clock) |-> aux_clock [*3])
    else $error("aux clock high phase too short");
  AST_TIMER_HIGH: assert property ($rose(timer0_clock) |-> timer0_clock [*3])
    else $error("timer clock high phase too short");
  AST_SERIAL_LOW: assert property ($fell(serial0_clock) |-> !serial0_clock [*3])
    else $error("serial clock low phase too short");
  AST_TRIM_STEP: assert property (!$stable(dco_trim) |->
    dco_trim == $past(dco_trim) + 9'h001 || dco_trim == $past(dco_trim) - 9'h001)
    else $error("trim moved by more than one step");
  AST_FAULT_CLEAR: assert property ($fell(crystal_fault) |->
    $past(take && hwrite && haddr[7:0] == `OFS_STATUS, 2) && $past(hwdata[0]))
    else $error("fault flag cleared without a clearing write");
  AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write inserted a wait state");
  AST_RDATA_HOLD: assert property (!$stable(hrdata) |-> $rose(hreadyout))
    else $error("read data changed outside a read completion");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("error response seen");
endmodule

`default_nettype wire

// >>> dv/osc_bank.sv
/*
  Free-running oscillator and pin clocks feeding the clock select block.
  Assumes clock is the system clock; source i has a half period of i+3 cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module osc_bank (
  input wire logic clock,
  input wire logic crystal_run,
  output wire logic [13:0] osc
);
  for (genvar i = 0; i < 14; i++) begin : g_osc
    logic lvl = 1'b0;
    int cnt = 0;
    assign osc[i] = lvl;
    // Crystal (index 2) can be stopped to provoke a fault
    always @(posedge clock) begin
      if (i != 2 || crystal_run) begin
        if (cnt == i + 2) begin
          cnt <= 0;
          lvl <= ~lvl;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// >>> dv/clock_select_and_distribution_test.sv
/*
  Self-checking bench for the clock select block: registers over AHB-Lite,
  clock selection identified by measured periods, fail-safe and trim.
  Assumes osc_bank half periods: dco 3, async_module_osc 4, crystal 5, vlo 6, rc 7, pins 8..16.
*/
`include "clock_select_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module clock_select_and_distribution_test;
  logic clock, nrst, hsel, hwrite, crystal_run;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata;
  wire [31:0] hrdata;
  wire hreadyout, crystal_fault;
  wire [8:0] dco_trim;
  wire [13:0] osc;
  wire [14:0] outs;
  int num_errors, comparisons, cycles;

  osc_bank i_osc (.clock(clock), .crystal_run(crystal_run), .osc(osc));

  clock_select_and_distribution i_dut (
    .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
    .crystal_osc_clock(osc[2]), .very_low_power_osc_clock(osc[3]),
    .internal_rc_32k_osc(osc[4]), .digitally_controlled_osc(osc[0]),
    .module_osc_clock(osc[1]), .timer0_ext_clock_pin(osc[5]), .timer1_ext_clock_pin(osc[6]),
    .timer2_ext_clock_pin(osc[7]), .timer3_ext_clock_pin(osc[8]),
    .timer_b_ext_clock_pin(osc[9]), .serial0_ext_clock_pin(osc[10]),
    .serial1_ext_clock_pin(osc[11]), .serial2_ext_clock_pin(osc[12]),
    .serial3_ext_clock_pin(osc[13]), .main_clock(outs[0]), .sub_system_clock(outs[1]),
    .aux_clock(outs[2]), .timer0_clock(outs[3]), .timer1_clock(outs[4]),
    .timer2_clock(outs[5]), .timer3_clock(outs[6]), .timer_b_clock(outs[7]),
    .serial0_clock(outs[8]), .serial1_clock(outs[9]), .serial2_clock(outs[10]),
    .serial3_clock(outs[11]), .watchdog_clock(outs[12]), .converter_clock(outs[13]),
    .rtc_clock(outs[14]), .dco_trim(dco_trim), .crystal_fault(crystal_fault)
  );

  always #25 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Period between the third and fourth rising edge; 0 if the output never runs
  task automatic check_clk(input int idx, input int half);
    int n, r, per;
    logic prev;
    n = 0;
    r = 0;
    per = 0;
    prev = outs[idx];
    while (n < half * 12 + 300 && r < 4) begin
      @(posedge clock);
      n++;
      if (r == 3) per++;
      if (outs[idx] === 1'b1 && prev === 1'b0) r++;
      prev = outs[idx];
    end
    if (r < 4) per = 0;
    check(32'(per), 32'(half * 2));
  endtask

  // Half period expected on peripheral slot s for select code c
  function automatic int exp_half(input int s, input int c, input bit ch);
    case (c)
      0: return s == 11 ? 0 : (s == 10 ? 4 : (s == 9 ? 24 : 8 + s));
      1: return (s == 11 && !ch) ? 24 : 7;
      2: return s == 11 ? 5 : (s == 9 ? 6 : 24);
      default: return s < 5 ? ((s == 0 || s == 2) ? 6 : 0) : (s == 9 ? 0 : (s == 11 ? 6 : 24));
    endcase
  endfunction

  task automatic t_regs();
    logic [31:0] rd;
    bus(1'b0, `OFS_MAIN_CTRL, 32'h0, rd);
    check(rd, `MAIN_CTRL_RESET);
    bus(1'b0, `OFS_FLL_CTRL, 32'h0, rd);
    check(rd, `FLL_CTRL_RESET);
    bus(1'b0, `OFS_PERIPH_SEL, 32'h0, rd);
    check(rd, `PERIPH_SEL_RESET);
    bus(1'b0, `OFS_STATUS, 32'h0, rd);
    check(rd & 32'h01FF0001, {7'h00, `TRIM_RESET, 16'h0000});
    bus(1'b1, 8'h10, 32'hFFFFFFFF, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h00000000);
  endtask

  task automatic t_main();
    logic [31:0] rd;
    int sh;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `OFS_MAIN_CTRL, {18'h0, 2'(i % 4), 2'h0, 2'(3 - i % 4), 1'h0, 3'(i), 2'h0,
          2'(i % 4)}, rd);
      sh = (i % 4 == 0) ? 3 : ((i % 4 == 1) ? 5 : ((i % 4 == 2) ? 7 : 6));
      check_clk(0, sh << i);
      check_clk(1, (sh << i) << (3 - i % 4));
      check_clk(2, i % 4 == 1 ? 6 : (i % 4 == 2 ? 7 : 5));
    end
  endtask

  task automatic t_periph();
    logic [31:0] rd, sel;
    logic [1:0] c;
    bus(1'b1, `OFS_MAIN_CTRL, 32'h00002300, rd);
    for (int k = 0; k < 5; k++) begin
      c = (k == 4) ? 2'h1 : 2'(k);
      sel = {7'h00, k == 4, {12{c}}};
      bus(1'b1, `OFS_PERIPH_SEL, sel, rd);
      bus(1'b0, `OFS_PERIPH_SEL, 32'h0, rd);
      check(rd, sel);
      for (int s = 0; s < 12; s++) begin
        check_clk(s + 3, exp_half(s, c, k == 4));
      end
    end
  endtask

  task automatic t_fault();
    logic [31:0] rd;
    int n;
    bus(1'b1, `OFS_MAIN_CTRL, 32'h00000300, rd);
    crystal_run <= 1'b0;
    n = 0;
    while (crystal_fault !== 1'b1 && n < 2100) begin
      @(posedge clock);
      n++;
    end
    check(32'(n > `XT_FAULT_CYCLES - 20 && n < `XT_FAULT_CYCLES + 30), 32'h1);
    crystal_run <= 1'b1;
    check_clk(2, 7);
    bus(1'b0, `OFS_STATUS, 32'h0, rd);
    check(rd & 32'h1, 32'h1);
    bus(1'b1, `OFS_STATUS, 32'h1, rd);
    bus(1'b0, `OFS_STATUS, 32'h0, rd);
    check(rd & 32'h1, 32'h0);
    check_clk(2, 5);
  endtask

  task automatic t_fll();
    logic [31:0] rd;
    logic [8:0] t;
    int n;
    bus(1'b1, `OFS_FLL_CTRL, 32'h00010010, rd);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) bus(1'b1, `OFS_FLL_CTRL, 32'h00010000, rd);
      t = dco_trim;
      n = 0;
      while (dco_trim === t && n < 200) begin
        @(posedge clock);
        n++;
      end
      check({23'h0, dco_trim}, {23'h0, k == 0 ? t + 9'h001 : t - 9'h001});
    end
    bus(1'b0, `OFS_STATUS, 32'h0, rd);
    check(rd & 32'h2, 32'h0);
    bus(1'b1, `OFS_FLL_CTRL, `FLL_CTRL_RESET, rd);
  endtask

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    crystal_run = 1'b1;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_regs();
    t_main();
    t_periph();
    t_fault();
    t_fll();
    finish_test();
  end
endmodule

bind clock_select_and_distribution clock_select_checker i_chk (
  .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .main_clock(main_clock),
  .sub_system_clock(sub_system_clock), .aux_clock(aux_clock), .timer0_clock(timer0_clock),
  .serial0_clock(serial0_clock), .dco_trim(dco_trim), .crystal_fault(crystal_fault)
);

`default_nettype wire
